// ==== src/pler_monitor.sv ====
// position loop entry capture, commanded velocity and position error monitor
`timescale 1ns/1ps
`default_nettype none
module pler_monitor
    import pler_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic signed [POS_W-1:0] position_command_in,
    input wire logic signed [POS_W-1:0] shaft_position_feedback,
    input wire logic [MODE_W-1:0] operating_mode_select,
    input wire logic trajectory_active,
    input wire logic position_error_interrupt_enable,
    input wire logic [POS_W-1:0] max_position_error_threshold,
    input wire logic fault_clear,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    output logic [POS_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic loop_tick,
    output logic position_error_fault,
    output logic position_error_irq
);
    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic logic [2:0] decode_addr(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_VEL_READOUT: decode_addr = SEL_VEL;
            OFS_CMD_READOUT: decode_addr = SEL_CMD;
            OFS_ERR_READOUT: decode_addr = SEL_ERR;
            default: decode_addr = 3'b000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // loop update divider
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] div_ff;
    logic tick_ff;

    always_ff @(posedge sys_clk) begin
        if (rst || div_ff == DIV_LAST) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        tick_ff <= !rst && div_ff == DIV_LAST;
    end

    assign loop_tick = tick_ff;

    // ----------------------------------------------------------------
    // capture, derivative and error
    // ----------------------------------------------------------------
    pler_readout_type rd_ff;
    logic in_pos_mode;
    logic vel_enable;
    logic signed [POS_W-1:0] nxt_err;
    logic [POS_W-1:0] err_mag;
    logic over_now;
    logic over_ff;

    assign in_pos_mode = operating_mode_select == MODE_POSITION;
    assign vel_enable = in_pos_mode && trajectory_active;
    assign nxt_err = shaft_position_feedback
        - position_command_in;
    assign err_mag = nxt_err[POS_W-1] ? POS_W'(-nxt_err) : nxt_err;
    // a zero threshold turns the check off entirely
    assign over_now = in_pos_mode && max_position_error_threshold != '0
        && err_mag > max_position_error_threshold;

    // one process owns the readout word, so its fields have a single driver
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ff.vel <= RST_READOUT;
            rd_ff.cmd <= RST_READOUT;
            rd_ff.err <= RST_READOUT;
        end else if (tick_ff) begin
            rd_ff.cmd <= position_command_in;
            // counts per loop period; scaling to units is software's job
            if (vel_enable) begin
                rd_ff.vel <= position_command_in
                    - rd_ff.cmd;
            end
            rd_ff.err <= in_pos_mode ? nxt_err : RST_READOUT;
        end
    end

    // ----------------------------------------------------------------
    // fault and interrupt event
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            over_ff <= 1'b0;
        end else if (tick_ff) begin
            over_ff <= over_now;
        end
    end

    // set wins over clear so a fresh overrun is never lost
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            position_error_fault <= 1'b0;
        end else if (tick_ff && over_now
                     && !position_error_interrupt_enable) begin
            position_error_fault <= 1'b1;
        end else if (fault_clear) begin
            position_error_fault <= 1'b0;
        end
    end

    // one event per entry into the overrun condition
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            position_error_irq <= 1'b0;
        end else begin
            position_error_irq <= tick_ff && over_now && !over_ff
                && position_error_interrupt_enable;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [2:0] sel;
    assign sel = decode_addr(reg_addr);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= RST_READOUT;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (sel)
                    SEL_VEL: reg_rdata <= rd_ff.vel;
                    SEL_CMD: reg_rdata <= rd_ff.cmd;
                    // error reads zero whenever not in position mode
                    SEL_ERR: reg_rdata <= in_pos_mode ? rd_ff.err
                        : RST_READOUT;
                    default: reg_rdata <= RST_READOUT;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    vel_hold_a: assert property (
        tick_ff && !vel_enable |=> $stable(rd_ff.vel))
        else $error("velocity changed outside mode 2 motion");
    vel_deriv_a: assert property (
        tick_ff && vel_enable |=>
        rd_ff.vel == $past(position_command_in) - $past(rd_ff.cmd))
        else $error("velocity is not the command difference");
    cmd_capture_a: assert property (
        tick_ff |=> rd_ff.cmd == $past(position_command_in))
        else $error("command not captured at loop entry");
    err_calc_a: assert property (
        tick_ff && in_pos_mode |=> rd_ff.err ==
        $past(shaft_position_feedback) - $past(position_command_in))
        else $error("error is not feedback minus command");

    // ----------------------------------------------------------------
    // read port checks
    // ----------------------------------------------------------------
    err_zero_a: assert property (
        reg_rd && sel == SEL_ERR && !in_pos_mode
        |=> reg_rvalid && reg_rdata == '0)
        else $error("error read nonzero outside position mode");
    vel_read_a: assert property (
        reg_rd && sel == SEL_VEL |=> reg_rdata == $past(rd_ff.vel))
        else $error("velocity read does not match readout");
    cmd_read_a: assert property (
        reg_rd && sel == SEL_CMD |=> reg_rdata == $past(rd_ff.cmd))
        else $error("command read does not match readout");
    rvalid_high_a: assert property (
        reg_rd |=> reg_rvalid)
        else $error("read answered without valid");
    rvalid_low_a: assert property (
        !reg_rd |=> !reg_rvalid)
        else $error("valid without a read request");

    // ----------------------------------------------------------------
    // fault and event checks
    // ----------------------------------------------------------------
    fault_suppress_a: assert property (
        $rose(position_error_fault) |->
        !$past(position_error_interrupt_enable))
        else $error("fault raised while interrupt enabled");
    irq_instead_a: assert property (
        tick_ff && over_now && !over_ff
        && position_error_interrupt_enable |=> position_error_irq)
        else $error("missing position error interrupt");
    irq_pulse_a: assert property (
        position_error_irq |=> !position_error_irq)
        else $error("interrupt event longer than one cycle");
    fault_set_a: assert property (
        tick_ff && over_now && !position_error_interrupt_enable
        |=> position_error_fault)
        else $error("overrun did not raise the fault");
    fault_hold_a: assert property (
        position_error_fault && !fault_clear |=> position_error_fault)
        else $error("fault dropped without a clear");
    thr_zero_a: assert property (
        max_position_error_threshold == '0
        |=> !$rose(position_error_fault))
        else $error("fault with threshold zero");
    tick_space_a: assert property (tick_ff |=> !tick_ff [*8])
        else $error("loop ticks too close");

    // ----------------------------------------------------------------
    // cover points
    // ----------------------------------------------------------------
    fault_cov_c: cover property ($rose(position_error_fault));
    irq_cov_c: cover property (position_error_irq);
    vel_cov_c: cover property (tick_ff && vel_enable);
    err_rd_cov_c: cover property (reg_rd && sel == SEL_ERR && in_pos_mode);
endmodule
`default_nettype wire

// ==== src/pler_pkg.sv ====
// constants, register map and carrier types of the position loop error monitor
package pler_pkg;
    // ----------------------------------------------------------------
    // widths and modes
    // ----------------------------------------------------------------
    localparam int unsigned POS_W = 64;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_POSITION = 4'h2;

    // ----------------------------------------------------------------
    // register offsets (read-only)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_VEL_READOUT = 12'h238;
    localparam logic [ADDR_W-1:0] OFS_CMD_READOUT = 12'h23a;
    localparam logic [ADDR_W-1:0] OFS_ERR_READOUT = 12'h23e;
    localparam logic [POS_W-1:0] RST_READOUT = 64'h0000_0000_0000_0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned LOOP_PERIOD_NS = 250000;
    localparam int unsigned LOOP_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 12;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LOOP_CYCLES - 1);

    // ----------------------------------------------------------------
    // carrier of the three readouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [POS_W-1:0] vel;
        logic signed [POS_W-1:0] cmd;
        logic signed [POS_W-1:0] err;
    } pler_readout_type;

    typedef enum logic [2:0] {
        SEL_VEL = 3'b001,
        SEL_CMD = 3'b010,
        SEL_ERR = 3'b100
    } pler_sel_type;
endpackage

// ==== test/pler_monitor_tb_top.sv ====
// self-checking bench of the position loop error monitor
`timescale 1ns/1ps
`default_nettype none
module pler_monitor_tb_top;
    import pler_pkg::*;
    logic sys_clk = 0, rst = 1, traj = 0, en = 0, clr = 0, rd = 0, adv = 0;
    logic [MODE_W-1:0] mode = 4'h0;
    logic [ADDR_W-1:0] addr = 12'h000;
    logic [POS_W-1:0] thr = 64'h0000_0000_0000_0000, rdata;
    logic signed [POS_W-1:0] step = 0, lag = 0, cmd, fb;
    logic rvalid, tick, fault, irq;
    int n_mismatch = 0, tests_run = 0;
    longint ro, vel, s, ee;
    bit pov, ov;
    logic [3:0] md [8] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h3, 4'h2, 4'h2, 4'h0};
    longint er [8] = '{700, 900, -600, 800, 900, 100, -501, 5};
    longint th [8] = '{500, 0, 500, 500, 500, 500, 500, 0};
    bit tj [8] = '{1, 1, 0, 1, 1, 1, 1, 0};
    bit ie [8] = '{0, 0, 1, 1, 0, 1, 0, 0};
    always #50 sys_clk = ~sys_clk;
    pler_partner FAR (.sys_clk(sys_clk), .adv(adv), .step(step), .lag(lag),
        .cmd(cmd), .fb(fb));
    pler_monitor DUT (.sys_clk(sys_clk), .rst(rst), .position_command_in(cmd),
        .shaft_position_feedback(fb), .operating_mode_select(mode),
        .trajectory_active(traj), .position_error_interrupt_enable(en),
        .max_position_error_threshold(thr), .fault_clear(clr),
        .reg_rd(rd), .reg_addr(addr), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .loop_tick(tick),
        .position_error_fault(fault), .position_error_irq(irq));
    // ----------------------------------------------------------------
    // checking tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] e,
        input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a read that misses its valid pulse compares as unknown
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [63:0] e,
        input string nm);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, (rvalid === 1'b1) ? rdata : 'x);
    endtask
    task automatic close_out;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(52413));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(OFS_VEL_READOUT, RST_READOUT, "vel0");
        rd_chk(OFS_CMD_READOUT, RST_READOUT, "cmd0");
        rd_chk(12'h23c, RST_READOUT, "hole");
        ro = 0;
        vel = 0;
        pov = 0;
        for (int i = 0; i < 8; i++) begin
            s = longint'($urandom_range(4000)) - 2000;
            @(posedge sys_clk);
            mode <= md[i];
            traj <= tj[i];
            en <= ie[i];
            thr <= th[i];
            lag <= er[i];
            step <= s;
            adv <= 1'b1;
            @(posedge sys_clk);
            adv <= 1'b0;
            #1;
            for (int n = 0; n < 3000 && tick !== 1'b1; n++) begin
                @(posedge sys_clk);
                #1;
            end
            chk("tick", 1'b1, tick);
            @(posedge sys_clk);
            #1;
            ov = md[i] == 4'h2 && th[i] != 0 && (er[i] < 0 ? -er[i] : er[i])
                > th[i];
            chk("irq", ov && ie[i] && !pov, irq);
            chk("fault", ov && !ie[i], fault);
            pov = ov;
            if (md[i] == 4'h2 && tj[i]) begin
                vel = s;
            end
            ro = ro + s;
            rd_chk(OFS_VEL_READOUT, vel, "vel");
            rd_chk(OFS_CMD_READOUT, ro, "cmd");
            ee = md[i] == 4'h2 ? er[i] : 0;
            rd_chk(OFS_ERR_READOUT, ee, "err");
            @(posedge sys_clk);
            clr <= 1'b1;
            @(posedge sys_clk);
            clr <= 1'b0;
            #1;
            chk("clear", 0, fault);
        end
        close_out();
    end
endmodule
`default_nettype wire

// ==== test/pler_partner.sv ====
// far-side model: trajectory command source and shaft feedback
`timescale 1ns/1ps
`default_nettype none
module pler_partner
    import pler_pkg::*;
(
    input wire logic sys_clk,
    input wire logic adv,
    input wire logic signed [POS_W-1:0] step,
    input wire logic signed [POS_W-1:0] lag,
    output logic signed [POS_W-1:0] cmd,
    output logic signed [POS_W-1:0] fb
);
    initial cmd = 64'h0000_0000_0000_0000;
    initial fb = 64'h0000_0000_0000_0000;
    // one move per loop period, so the loop always sees a settled pair
    always @(posedge sys_clk) begin
        if (adv) begin
            cmd <= cmd + step;
            fb <= cmd + step + lag;
        end
    end
endmodule
`default_nettype wire
